//--- src/idimg_core.sv
`timescale 1ns/1ps
`include "idimg_params.svh"
// How it works
// [RL1] word 49 bit 13 standby timer flag
// [RL2] word 49 bits 11,10 flow-control flags
// [RL3] word 51 upper byte PIO mode
// [RL4] word 53 validity bits 1 and 0
// [RL5] words 54-58 current geometry and capacity
// [RL6] word 59 multiple-sector valid and count
// [RL7] words 60-61 fixed LBA sector total
// [RL8] word 63 DMA supported low, active high
// [RL9] word 64 advanced PIO map, upper zero
// [RL10] words 65-68 cycle times in ns
// [RL11] word 80 major revision flags
// [RL12] word 81 minor version code
// [RL13] word 82 feature set support bits
// [RL14] host ignores 82/83 both 0000h/FFFFh
// [RL15] word 83 reads 4000h always
// [RL16] word 128 security level and flags
// [RL17] reserved words and bits read zero
// [RL18] fixed words constant unless media changes
// [RL19] identify: busy, build, drq, interrupt
// [RL20] 32-bit fields low word first
// [RL21] read pointer restarts on each identify
module idimg_core #(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire idimg_pkg::idimg_fixed_s fixed_i,
    input wire idimg_pkg::idimg_var_s var_i,
    input wire logic media_changed_i,
    input wire logic identify_i,
    input wire logic data_rd_i,
    output logic [15:0] data_o,
    output logic busy_o,
    output logic drq_o,
    output logic intrq_o,
    output logic [7:0] word_idx_o
);
    import idimg_pkg::*;

    // every check below runs on the one core clock
    default clocking cb_core @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    idimg_regs_s r_ff;
    idimg_regs_s nxt_r;
    logic [15:0] word_val;
    logic [15:0] fifo_out;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [7:0] rd_ptr_ff;
    logic [7:0] nxt_rd_ptr;
    logic [15:0] data_ff;
    logic intrq_ff;
    logic nxt_intrq;
    logic started_ff;
    logic push;
    logic pop;

    // ===========================================================
    // image word generator
    // ===========================================================
    // latched fixed copy keeps fixed words steady between media changes, even mid-run
    always_comb begin
        word_val = `IDIMG_ZERO; // reserved words default to zero [RL17]
        if (r_ff.wr_ptr == `IDIMG_W_CAPS) begin
            word_val[`IDIMG_BIT_STBY] = r_ff.fixed.std_standby; // [RL1]
            word_val[`IDIMG_BIT_FC] = r_ff.fixed.fc_supported; // [RL2]
            word_val[`IDIMG_BIT_FCOFF] = r_ff.fixed.fc_can_disable; // [RL2]
            word_val[7:0] = r_ff.fixed.caps_vendor;
        end else if (r_ff.wr_ptr == `IDIMG_W_PIOMODE) begin
            word_val = {r_ff.fixed.pio_mode, r_ff.fixed.pio_vendor}; // [RL3]
        end else if (r_ff.wr_ptr == `IDIMG_W_VALID) begin
            word_val[1:0] = {r_ff.fixed.adv_valid, var_i.geo_valid}; // [RL4]
        end else if (r_ff.wr_ptr == `IDIMG_W_CYLS) begin
            word_val = var_i.cyls; // [RL5]
        end else if (r_ff.wr_ptr == `IDIMG_W_HEADS) begin
            word_val = var_i.heads; // [RL5]
        end else if (r_ff.wr_ptr == `IDIMG_W_SPT) begin
            word_val = var_i.spt; // [RL5]
        end else if (r_ff.wr_ptr == `IDIMG_W_CAPLO) begin
            word_val = var_i.capacity[15:0]; // [RL5] [RL20]
        end else if (r_ff.wr_ptr == `IDIMG_W_CAPHI) begin
            word_val = var_i.capacity[31:16]; // [RL20]
        end else if (r_ff.wr_ptr == `IDIMG_W_MULT) begin
            word_val[`IDIMG_BIT_MVALID] = var_i.mult_valid; // [RL6]
            word_val[7:0] = var_i.mult_count; // [RL6]
        end else if (r_ff.wr_ptr == `IDIMG_W_LBALO) begin
            word_val = r_ff.fixed.lba_total[15:0]; // [RL7] [RL20]
        end else if (r_ff.wr_ptr == `IDIMG_W_LBAHI) begin
            word_val = r_ff.fixed.lba_total[31:16]; // [RL7]
        end else if (r_ff.wr_ptr == `IDIMG_W_DMA) begin
            word_val = {var_i.dma_active, r_ff.fixed.dma_supported}; // [RL8]
        end else if (r_ff.wr_ptr == `IDIMG_W_APIO) begin
            word_val[7:0] = r_ff.fixed.apio_supported; // [RL9]
        end else if (r_ff.wr_ptr == `IDIMG_W_DMAMIN) begin
            word_val = r_ff.fixed.dma_min_ns; // [RL10]
        end else if (r_ff.wr_ptr == `IDIMG_W_DMAREC) begin
            word_val = r_ff.fixed.dma_rec_ns; // [RL10]
        end else if (r_ff.wr_ptr == `IDIMG_W_PIOMIN) begin
            word_val = r_ff.fixed.pio_min_ns; // [RL10]
        end else if (r_ff.wr_ptr == `IDIMG_W_PIOFC) begin
            word_val = r_ff.fixed.pio_fc_ns; // [RL10]
        end else if (r_ff.wr_ptr == `IDIMG_W_MAJOR) begin
            word_val = r_ff.fixed.major_ver; // [RL11]
        end else if (r_ff.wr_ptr == `IDIMG_W_MINOR) begin
            word_val = r_ff.fixed.minor_ver; // [RL12]
        end else if (r_ff.wr_ptr == `IDIMG_W_CMDSET) begin
            word_val[2:0] = r_ff.fixed.feat_set; // [RL13]
        end else if (r_ff.wr_ptr == `IDIMG_W_CMDSET2) begin
            word_val = `IDIMG_CMDSET2_VAL; // [RL15] [RL14]
        end else if (r_ff.wr_ptr == `IDIMG_W_SECUR) begin
            word_val[`IDIMG_BIT_SECLVL] = r_ff.fixed.sec_level; // [RL16]
            word_val[4:0] = r_ff.fixed.sec_flags; // [RL16]
        end else if (r_ff.wr_ptr >= `IDIMG_W_VEND_LO
                     && r_ff.wr_ptr <= `IDIMG_W_VEND_HI) begin
            word_val = `IDIMG_ZERO; // vendor area left blank
        end
    end

    // ===========================================================
    // command sequencer
    // ===========================================================
    assign push = (r_ff.state == IDIMG_BUSY) && fifo_in_ready;
    assign pop = data_rd_i && fifo_out_valid && (r_ff.state == IDIMG_XFER);

    always_comb begin
        nxt_r = r_ff;
        nxt_intrq = 1'b0;
        nxt_rd_ptr = rd_ptr_ff;
        // fixed copy refreshes on a media change, besides the one sample after reset release [RL18]
        if (media_changed_i) begin
            nxt_r.fixed = fixed_i;
        end
        case (r_ff.state)
            IDIMG_IDLE: begin
                if (identify_i) begin
                    nxt_r.state = IDIMG_BUSY; // [RL19]
                    nxt_r.wr_ptr = `IDIMG_W_FIRST;
                    nxt_rd_ptr = `IDIMG_W_FIRST; // [RL21]
                end
            end
            IDIMG_BUSY: begin
                // prefill until fifo full, then hand over to host
                if (!fifo_in_ready || (push
                    && r_ff.wr_ptr == `IDIMG_W_LAST)) begin
                    nxt_r.state = IDIMG_XFER; // [RL19]
                    nxt_intrq = 1'b1; // [RL19]
                end
                if (push && r_ff.wr_ptr != `IDIMG_W_LAST) begin
                    nxt_r.wr_ptr = r_ff.wr_ptr + 8'h01;
                end else if (push) begin
                    // image fitted the fifo: nothing left to refill
                    nxt_r.media_seen = 1'b0;
                end
                // a new identify mid-build starts over [RL21]
                if (identify_i) begin
                    nxt_r.state = IDIMG_BUSY;
                    nxt_r.wr_ptr = `IDIMG_W_FIRST;
                    nxt_rd_ptr = `IDIMG_W_FIRST;
                    nxt_intrq = 1'b0;
                end
            end
            IDIMG_XFER: begin
                // refill behind the host's reads
                if (fifo_in_ready && r_ff.media_seen) begin
                    if (r_ff.wr_ptr != `IDIMG_W_LAST) begin
                        nxt_r.wr_ptr = r_ff.wr_ptr + 8'h01;
                    end else begin
                        nxt_r.media_seen = 1'b0;
                    end
                end
                if (pop) begin
                    nxt_rd_ptr = rd_ptr_ff + 8'h01; // [RL21]
                    if (rd_ptr_ff == `IDIMG_W_LAST) begin
                        nxt_r.state = IDIMG_IDLE;
                    end
                end
                if (identify_i) begin
                    nxt_r.state = IDIMG_BUSY; // restart [RL21]
                    nxt_r.wr_ptr = `IDIMG_W_FIRST;
                    nxt_rd_ptr = `IDIMG_W_FIRST;
                end
            end
            default: begin
                nxt_r.state = IDIMG_IDLE;
            end
        endcase
        // media_seen here marks that words remain to be pushed
        if (nxt_r.state == IDIMG_BUSY) begin
            nxt_r.media_seen = 1'b1;
        end
    end

    // fixed copy sampled one cycle after reset release
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            r_ff <= '{state: IDIMG_IDLE, wr_ptr: 8'h00,
                      media_seen: 1'b0, fixed: '0};
            rd_ptr_ff <= 8'h00;
            intrq_ff <= 1'b0;
            started_ff <= 1'b0;
            data_ff <= 16'h0000;
        end else begin
            r_ff <= nxt_r;
            if (!started_ff) begin
                r_ff.fixed <= fixed_i;
            end
            started_ff <= 1'b1;
            rd_ptr_ff <= nxt_rd_ptr;
            intrq_ff <= nxt_intrq;
            if (pop) begin
                data_ff <= fifo_out; // registered data out
            end
        end
    end

    // ===========================================================
    // word buffer between generator and data port
    // ===========================================================
    idimg_fifo #(
        .WIDTH(16),
        .DEPTH(FIFO_DEPTH)
    ) idimg_fifo_inst (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .in_valid_i(push || (r_ff.state == IDIMG_XFER
                    && r_ff.media_seen)),
        .in_ready_o(fifo_in_ready),
        .in_data_i(word_val),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(pop),
        .out_data_o(fifo_out),
        .flush_i(identify_i)
    );

    assign data_o = data_ff;
    assign busy_o = (r_ff.state == IDIMG_BUSY);
    assign drq_o = (r_ff.state == IDIMG_XFER) && fifo_out_valid;
    assign intrq_o = intrq_ff;
    assign word_idx_o = rd_ptr_ff;

    // ===========================================================
    // checks
    // ===========================================================
    a_word83_const: assert property ( // [RL15]
        r_ff.wr_ptr == `IDIMG_W_CMDSET2 |-> word_val == 16'h4000)
        else $error("word 83 not 4000h");
    a_busy_before_drq: assert property ( // [RL19]
        $rose(drq_o) |-> $past(busy_o))
        else $error("drq without busy");
    a_irq_on_ready: assert property ( // [RL19]
        $fell(busy_o) && r_ff.state == IDIMG_XFER |-> intrq_o)
        else $error("no interrupt at data ready");
    a_ptr_restart: assert property ( // [RL21]
        identify_i |=> word_idx_o == 8'h31)
        else $error("pointer not restarted");
    a_ptr_step: assert property ( // [RL21]
        pop && !identify_i |=> word_idx_o == $past(word_idx_o) + 8'h01)
        else $error("pointer did not step");
    a_w49_resvd: assert property ( // [RL1]
        r_ff.wr_ptr == `IDIMG_W_CAPS |-> word_val[15:14] == 2'h0
        && word_val[12] == 1'b0 && word_val[9:8] == 2'h0)
        else $error("word 49 reserved bits set");
    a_w53_resvd: assert property ( // [RL4]
        r_ff.wr_ptr == `IDIMG_W_VALID |-> word_val[15:2] == 14'h0000)
        else $error("word 53 reserved bits set");
    a_w59_resvd: assert property ( // [RL6]
        r_ff.wr_ptr == `IDIMG_W_MULT |-> word_val[15:9] == 7'h00)
        else $error("word 59 reserved bits set");
    a_w64_upper: assert property ( // [RL9]
        r_ff.wr_ptr == `IDIMG_W_APIO |-> word_val[15:8] == 8'h00)
        else $error("word 64 upper byte set");
    a_w82_resvd: assert property ( // [RL13]
        r_ff.wr_ptr == `IDIMG_W_CMDSET |-> word_val[15:4] == 12'h000)
        else $error("word 82 reserved bits set");
    a_resvd_zero: assert property ( // [RL17]
        r_ff.wr_ptr >= 8'hA0 |-> word_val == 16'h0000)
        else $error("reserved word not zero");
    a_w128_resvd: assert property ( // [RL16]
        r_ff.wr_ptr == `IDIMG_W_SECUR |-> word_val[7:5] == 3'h0
        && word_val[15:9] == 7'h00)
        else $error("word 128 reserved bits set");
    a_fixed_hold: assert property ( // [RL18]
        started_ff && !$past(media_changed_i) && $past(started_ff)
        |-> $stable(r_ff.fixed))
        else $error("fixed words changed");
    c_identify: cover property (@(posedge clk_i) identify_i);
    c_drq: cover property (@(posedge clk_i) $rose(drq_o));
    c_last_read: cover property (@(posedge clk_i)
        pop && rd_ptr_ff == 8'hFF);
    c_restart: cover property (@(posedge clk_i)
        identify_i && r_ff.state == IDIMG_XFER);
endmodule

// ===========================================================
// word buffer
// ===========================================================
// small fifo with valid/ready on both sides; depth a power of two
module idimg_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic flush_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0] rd_ff;
    logic [AW:0] wr_ff;
    logic do_wr;
    logic do_rd;

    // full when pointers differ only in the wrap bit
    assign in_ready_o = !((rd_ff[AW] != wr_ff[AW])
                          && (rd_ff[AW-1:0] == wr_ff[AW-1:0]));
    assign out_valid_o = (rd_ff != wr_ff);
    assign out_data_o = mem_ff[rd_ff[AW-1:0]];
    assign do_wr = in_valid_i && in_ready_o;
    assign do_rd = out_valid_o && out_ready_i;

    // pointers; flush drops whatever a stale command left behind
    always_ff @(posedge clk_i) begin
        if (reset_i || flush_i) begin
            rd_ff <= '0;
            wr_ff <= '0;
        end else begin
            if (do_wr) begin
                wr_ff <= wr_ff + 1'b1;
            end
            if (do_rd) begin
                rd_ff <= rd_ff + 1'b1;
            end
        end
    end

    // storage carries no reset
    always_ff @(posedge clk_i) begin
        if (do_wr) begin
            mem_ff[wr_ff[AW-1:0]] <= in_data_i;
        end
    end
endmodule

//--- pkg/idimg_params.svh
`ifndef IDIMG_PARAMS_SVH
`define IDIMG_PARAMS_SVH
// word indices of the identification image
`define IDIMG_W_CAPS 8'h31
`define IDIMG_W_PIOMODE 8'h33
`define IDIMG_W_VALID 8'h35
`define IDIMG_W_CYLS 8'h36
`define IDIMG_W_HEADS 8'h37
`define IDIMG_W_SPT 8'h38
`define IDIMG_W_CAPLO 8'h39
`define IDIMG_W_CAPHI 8'h3A
`define IDIMG_W_MULT 8'h3B
`define IDIMG_W_LBALO 8'h3C
`define IDIMG_W_LBAHI 8'h3D
`define IDIMG_W_DMA 8'h3F
`define IDIMG_W_APIO 8'h40
`define IDIMG_W_DMAMIN 8'h41
`define IDIMG_W_DMAREC 8'h42
`define IDIMG_W_PIOMIN 8'h43
`define IDIMG_W_PIOFC 8'h44
`define IDIMG_W_MAJOR 8'h50
`define IDIMG_W_MINOR 8'h51
`define IDIMG_W_CMDSET 8'h52
`define IDIMG_W_CMDSET2 8'h53
`define IDIMG_W_SECUR 8'h80
`define IDIMG_W_VEND_LO 8'h81
`define IDIMG_W_VEND_HI 8'h9F
`define IDIMG_W_FIRST 8'h31
`define IDIMG_W_LAST 8'hFF
// fixed field values
`define IDIMG_CMDSET2_VAL 16'h4000
`define IDIMG_ZERO 16'h0000
`define IDIMG_BIT_STBY 13
`define IDIMG_BIT_FC 11
`define IDIMG_BIT_FCOFF 10
`define IDIMG_BIT_MVALID 8
`define IDIMG_BIT_SECLVL 8
`endif

//--- pkg/idimg_pkg.sv
package idimg_pkg;
    // state one-hot codes
    typedef enum logic [2:0] {
        IDIMG_IDLE = 3'h1,
        IDIMG_BUSY = 3'h2,
        IDIMG_XFER = 3'h4
    } idimg_state_e;

    // fixed capability settings, sampled at reset release
    typedef struct packed {
        logic std_standby;
        logic fc_supported;
        logic fc_can_disable;
        logic [7:0] caps_vendor;
        logic [7:0] pio_mode;
        logic [7:0] pio_vendor;
        logic adv_valid;
        logic [31:0] lba_total;
        logic [7:0] dma_supported;
        logic [7:0] apio_supported;
        logic [15:0] dma_min_ns;
        logic [15:0] dma_rec_ns;
        logic [15:0] pio_min_ns;
        logic [15:0] pio_fc_ns;
        logic [15:0] major_ver;
        logic [15:0] minor_ver;
        logic [2:0] feat_set;
        logic sec_level;
        logic [4:0] sec_flags;
    } idimg_fixed_s;

    // variable state, may change between commands
    typedef struct packed {
        logic geo_valid;
        logic [15:0] cyls;
        logic [15:0] heads;
        logic [15:0] spt;
        logic [31:0] capacity;
        logic mult_valid;
        logic [7:0] mult_count;
        logic [7:0] dma_active;
    } idimg_var_s;

    typedef struct packed {
        idimg_state_e state;
        logic [7:0] wr_ptr;
        logic media_seen;
        idimg_fixed_s fixed;
    } idimg_regs_s;
endpackage

//--- src/idimg_fifo.sv
// the word buffer module is declared beside the core that owns it

//--- testbench/idimg_host.sv
`timescale 1ns/1ps
// ==========================================
// host adapter model: reads data words while drq is high
module idimg_host (
    input wire logic clk_i,
    input wire logic en_i,
    input wire logic slow_i,
    input wire logic clr_i,
    input wire logic drq_i,
    input wire logic [15:0] data_i,
    output logic rd_o,
    output int cnt_o,
    output logic cmdset_ok_o
);
    logic [15:0] img [0:255];
    logic pend = 1'h0;
    logic tog = 1'h0;
    initial rd_o = 1'h0;
    initial cnt_o = 49;
    // read only once drq has settled; slow mode reads every other cycle
    always @(posedge clk_i) begin
        #1;
        tog = ~tog;
        rd_o = en_i && drq_i && (!slow_i || tog);
    end
    // data lands the edge after an accepted read, so log it a cycle on
    always @(negedge clk_i) begin
        if (clr_i) begin
            cnt_o = 49;
        end else if (pend) begin
            img[cnt_o[7:0]] = data_i;
            cnt_o = cnt_o + 1;
        end
        pend = rd_o && drq_i;
    end
    // reporting absent when both words are all zeros or all ones
    assign cmdset_ok_o = !((img[82] === 16'h0000 && img[83] === 16'h0000) ||
        (img[82] === 16'hFFFF && img[83] === 16'hFFFF));
endmodule

//--- testbench/identify_data_words_49_to_255_tb.sv
`timescale 1ns/1ps
// ==========================================
// bench for the identification image, words 49 to 255
module identify_data_words_49_to_255_tb;
    import idimg_pkg::*;
    logic clk_i = 1'h0;
    logic reset_i = 1'h1;
    idimg_fixed_s fx, f;
    idimg_var_s v;
    logic media_changed_i = 1'h0;
    logic identify_i = 1'h0;
    logic tb_rd = 1'h0;
    logic host_en = 1'h0;
    logic host_slow = 1'h0;
    logic host_clr = 1'h0;
    logic host_rd, cmdset_ok, busy_o, drq_o, intrq_o;
    logic [15:0] data_o;
    logic [7:0] word_idx_o;
    int host_cnt;
    int err_count = 0;
    int comparisons = 0;

    always #5 clk_i = ~clk_i;

    idimg_core idimg_core_inst (.clk_i(clk_i), .reset_i(reset_i),
        .fixed_i(fx), .var_i(v), .media_changed_i(media_changed_i),
        .identify_i(identify_i), .data_rd_i(host_rd | tb_rd),
        .data_o(data_o), .busy_o(busy_o), .drq_o(drq_o),
        .intrq_o(intrq_o), .word_idx_o(word_idx_o));
    idimg_host idimg_host_inst (.clk_i(clk_i), .en_i(host_en),
        .slow_i(host_slow), .clr_i(host_clr), .drq_i(drq_o),
        .data_i(data_o), .rd_o(host_rd), .cnt_o(host_cnt),
        .cmdset_ok_o(cmdset_ok));

    // ==========================================
    // reporting
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic fail(input string msg);
        err_count++;
        $display("ERROR at %0t: %s", $time, msg);
        end_of_test();
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp,
            input string msg);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic tick();
        @(posedge clk_i);
        #1;
    endtask

    // expected word worked out from the field layout, f is the fixed copy
    function automatic logic [15:0] exp_word(input int w);
        case (w)
            49: exp_word = {2'h0, f.std_standby, 1'h0, f.fc_supported,
                f.fc_can_disable, 2'h0, f.caps_vendor};
            51: exp_word = {f.pio_mode, f.pio_vendor};
            53: exp_word = {14'h0, f.adv_valid, v.geo_valid};
            54: exp_word = v.cyls;
            55: exp_word = v.heads;
            56: exp_word = v.spt;
            57: exp_word = v.capacity[15:0];
            58: exp_word = v.capacity[31:16];
            59: exp_word = {7'h0, v.mult_valid, v.mult_count};
            60: exp_word = f.lba_total[15:0];
            61: exp_word = f.lba_total[31:16];
            63: exp_word = {v.dma_active, f.dma_supported};
            64: exp_word = {8'h0, f.apio_supported};
            65: exp_word = f.dma_min_ns;
            66: exp_word = f.dma_rec_ns;
            67: exp_word = f.pio_min_ns;
            68: exp_word = f.pio_fc_ns;
            80: exp_word = f.major_ver;
            81: exp_word = f.minor_ver;
            82: exp_word = {13'h0, f.feat_set};
            83: exp_word = 16'h4000;
            128: exp_word = {7'h0, f.sec_level, 3'h0, f.sec_flags};
            default: exp_word = 16'h0000;
        endcase
    endfunction

    // ==========================================
    // shared sequences
    task automatic start_id();
        int n;
        identify_i = 1'h1;
        tick();
        identify_i = 1'h0;
        tick();
        check(busy_o, 1'h1, "busy after identify");
        n = 0;
        while (intrq_o !== 1'h1 && n < 40) begin
            tick();
            n++;
        end
        if (n == 40) fail("no interrupt");
        check(drq_o, 1'h1, "drq with interrupt");
        check(busy_o, 1'h0, "busy cleared");
        check(word_idx_o, 8'h31, "pointer at word 49");
        tick();
        check(intrq_o, 1'h0, "interrupt lasts one cycle");
    endtask

    // host reads the whole image, then every word is compared
    task automatic read_all(input logic slow);
        int n;
        host_clr = 1'h1;
        host_slow = slow;
        tick();
        host_clr = 1'h0;
        host_en = 1'h1;
        n = 0;
        while (host_cnt < 256 && n < 1000) begin
            tick();
            n++;
        end
        if (n == 1000) fail("image read hung");
        tick();
        host_en = 1'h0;
        check(drq_o, 1'h0, "drq low after word 255");
        for (int w = 49; w < 256; w++) begin
            check(idimg_host_inst.img[w], exp_word(w), $sformatf("word %0d",
                w));
        end
        check(cmdset_ok, 1'h1, "command set reporting");
        check(idimg_host_inst.img[62], 16'h0000, "word 62");
    endtask

    // ==========================================
    // scenarios
    task automatic t_full();
        start_id();
        read_all(1'h0);
        $display("test full done");
    endtask

    task automatic t_restart();
        int n;
        start_id();
        host_clr = 1'h1;
        host_slow = 1'h1;
        tick();
        host_clr = 1'h0;
        host_en = 1'h1;
        n = 0;
        while (host_cnt < 70 && n < 300) begin
            tick();
            n++;
        end
        if (n == 300) fail("partial read hung");
        host_en = 1'h0;
        tick();
        start_id();
        read_all(1'h1);
        $display("test restart done");
    endtask

    // geometry changes show; fixed words wait for a media change
    task automatic t_change();
        v.cyls = 16'h1234;
        v.capacity = 32'hCAFE_0042;
        v.geo_valid = 1'h0;
        v.dma_active = 8'h04;
        v.mult_valid = 1'h0;
        fx.lba_total = 32'h7654_0001;
        fx.std_standby = 1'h0;
        fx.fc_can_disable = 1'h1;
        fx.major_ver = 16'h0006;
        start_id();
        read_all(1'h0);
        media_changed_i = 1'h1;
        tick();
        media_changed_i = 1'h0;
        f = fx;
        tick();
        start_id();
        read_all(1'h0);
        $display("test change done");
    endtask

    task automatic t_refuse();
        logic [15:0] d;
        d = data_o;
        tb_rd = 1'h1;
        tick();
        tb_rd = 1'h0;
        tick();
        check(data_o, d, "read without drq ignored");
        check(word_idx_o, 8'h00, "pointer held");
        // reads while the image is still being built must be ignored too
        identify_i = 1'h1;
        tick();
        identify_i = 1'h0;
        tb_rd = 1'h1;
        repeat (3) tick();
        tb_rd = 1'h0;
        check(busy_o, 1'h1, "still building");
        check(data_o, d, "read while busy ignored");
        check(word_idx_o, 8'h31, "pointer held while busy");
        read_all(1'h0);
        $display("test refuse done");
    endtask

    // ==========================================
    // main sequence
    initial begin
        fx = '{std_standby: 1'h1, fc_supported: 1'h1, fc_can_disable: 1'h0,
            caps_vendor: 8'hA5, pio_mode: 8'h02, pio_vendor: 8'h3C,
            adv_valid: 1'h1, lba_total: 32'h0012_3456,
            dma_supported: 8'h07, apio_supported: 8'h03,
            dma_min_ns: 16'h0078, dma_rec_ns: 16'h0096,
            pio_min_ns: 16'h00B4, pio_fc_ns: 16'h0078,
            major_ver: 16'h000E, minor_ver: 16'h0010, feat_set: 3'h5,
            sec_level: 1'h1, sec_flags: 5'h13};
        v = '{geo_valid: 1'h1, cyls: 16'h03FF, heads: 16'h0010,
            spt: 16'h003F, capacity: 32'h000F_BC10, mult_valid: 1'h1,
            mult_count: 8'h10, dma_active: 8'h02};
        f = fx;
        repeat (4) tick();
        reset_i = 1'h0;
        check({busy_o, drq_o, intrq_o}, 3'h0, "flags at reset");
        check(word_idx_o, 8'h00, "pointer at reset");
        tick();
        t_full();
        t_refuse();
        t_restart();
        t_change();
        end_of_test();
    end
endmodule
